// *** hdl/oig_pkg.sv ***
/*
  Shared constants for the cable identification and bus power monitor block:
  APB register offsets, bit positions, reset values and timing figures.
  Assumes a single 125 MHz core clock and an APB master on the register side.
*/
`default_nettype none
package oig_pkg;
  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OIG_OTG_CTRL_ADDR = 8'h00;
  localparam logic [7:0] OIG_INT_EN_RISE_ADDR = 8'h04;
  localparam logic [7:0] OIG_INT_EN_FALL_ADDR = 8'h08;
  localparam logic [7:0] OIG_INT_STAT_ADDR = 8'h0C;
  localparam logic [7:0] OIG_INT_LATCH_ADDR = 8'h10;
  localparam logic [7:0] OIG_CARKIT_STAT_ADDR = 8'h14;
  localparam logic [7:0] OIG_RID_ADDR = 8'h18;
  localparam logic [7:0] OIG_EXT_IND_ADDR = 8'h1C;
  // ==========================================================================
  // OTG control bits
  localparam int OIG_CTRL_ID_PULLUP_BIT = 0;
  localparam int OIG_CTRL_DISCHARGE_BIT = 3;
  localparam int OIG_CTRL_CHARGE_BIT = 4;
  // Interrupt enable and status bits
  localparam int OIG_INT_BUS_VALID_BIT = 1;
  localparam int OIG_INT_SESS_VALID_BIT = 2;
  localparam int OIG_INT_SESS_END_BIT = 3;
  localparam int OIG_INT_ID_GND_BIT = 4;
  // Carkit enable and status bit for the float comparator
  localparam int OIG_CK_ID_FLOAT_BIT = 0;
  // Synchronous mode, conversion start and conversion busy flag
  localparam int OIG_RID_START_BIT = 4;
  localparam int OIG_RID_BUSY_BIT = 5;
  localparam int OIG_RID_SYNC_BIT = 6;
  // External indicator selection bits
  localparam int OIG_EXT_USE_BIT = 0;
  localparam int OIG_EXT_PASS_BIT = 1;
  localparam int OIG_EXT_COMPL_BIT = 2;
  // ==========================================================================
  // Reset values
  localparam logic [7:0] OIG_CTRL_RESET = 8'h00;
  localparam logic [7:0] OIG_INT_EN_RESET = 8'h1F;
  localparam logic [7:0] OIG_EXT_RESET = 8'h00;
  // ==========================================================================
  // Identification resistance codes
  localparam logic [2:0] OIG_RID_GROUND = 3'h0;
  localparam logic [2:0] OIG_RID_R75 = 3'h1;
  localparam logic [2:0] OIG_RID_R102K = 3'h2;
  localparam logic [2:0] OIG_RID_R200K = 3'h3;
  localparam logic [2:0] OIG_RID_R440K = 3'h4;
  localparam logic [2:0] OIG_RID_FLOAT = 3'h5;
  // ==========================================================================
  // Timing
  localparam int OIG_CLK_MHZ = 125;
  localparam int OIG_RID_CONV_NS = 200;
  localparam int OIG_RID_CONV_CYC = (OIG_RID_CONV_NS * OIG_CLK_MHZ + 999) / 1000;
  localparam int OIG_SYNC_STAGES = 2;
endpackage
`default_nettype wire

// *** hdl/oig_sync.sv ***
/*
  Two flip-flop synchroniser for one asynchronous comparator level.
  Assumes the input may change at any time relative to the clock.
*/
`default_nettype none
module oig_sync (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_q;
  // ==========================================================================
  // First stage feeds only the second stage
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      meta_q <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

// *** hdl/oig_edge.sv ***
/*
  Edge detector on an already synchronised level, gated by rise and fall
  enables. Assumes the level input is synchronous to the clock.
*/
`default_nettype none
module oig_edge (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic level_in,
  input wire logic rise_en_in,
  input wire logic fall_en_in,
  output logic event_out
);
  import oig_pkg::*;
  // Hold off until the sync stages show a real level, else reset looks like an edge
  localparam logic [1:0] ARM_CYC = 2'(OIG_SYNC_STAGES + 1);
  logic prev_q;
  logic [1:0] arm_q;
  // ==========================================================================
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      prev_q <= 1'b0;
      arm_q <= 2'h0;
      event_out <= 1'b0;
    end else begin
      prev_q <= level_in;
      if (arm_q != ARM_CYC) begin
        arm_q <= arm_q + 2'h1;
      end
      event_out <= (arm_q == ARM_CYC)
        & ((rise_en_in & level_in & ~prev_q) | (fall_en_in & ~level_in & prev_q));
    end
  end
endmodule
`default_nettype wire

// *** hdl/oig_otg_ctrl.sv ***
/*
  Cable identification and bus power monitor control and status for an OTG
  capable transceiver. Holds the OTG control, interrupt enable, status,
  carkit status, resistance code and external indicator registers, reached
  over APB. Drives the analog switch enables, and raises a one-cycle event
  pulse with an alternate flag toward the receive command path.
  Assumes comparator inputs are asynchronous levels and that the resistance
  converter result arrives as a 3-bit code with a done strobe.
*/
// The APB register port and the placing of the registers were chosen for this implementation.
// How it works
// - ID grounded flag reads 0 for grounded pin, 1 for floating pin.
// - With pull-up off, a falling ID grounded comparator still raises an event.
// - Resistance code: ground 000, 75R 001, 102k 010, 200k 011, 440k 100, open 101.
// - Resistance code readable only in synchronous mode; link starts conversion.
// - Float comparator change sends an alternate event when both enables set.
// - With pull-up and float enables, flags follow the float comparator table.
// - ID grounded at status bit 4, ID floating at carkit status bit 0.
// - ID grounded change raises an event when its enables are set.
// - Bus valid, session valid and session end states readable in status.
// - Session end flag rises when bus voltage drops below 0.5 V.
// - Session end enables both clear: comparator off, status reads 0.
// - Session valid enables both clear: only events stop, status readable.
// - Bus valid enables both clear: comparator off, status bit 1 reads 0.
// - Receive command bus valid source follows the external indicator selection.
// - External indicator selection is disabled after reset.
// - OTG control bit 3 switches on the bus discharge pull-down.
// - OTG control bit 4 switches on the bus charge pull-up.
// - All status, register and event activity is on one rising clock edge.
`default_nettype none
module oig_otg_ctrl (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Analog comparator levels
  input wire logic ident_grounded_cmp_in,
  input wire logic ident_floating_cmp_in,
  input wire logic bus_power_valid_cmp_in,
  input wire logic session_valid_cmp_in,
  input wire logic session_end_cmp_in,
  // Resistance converter
  input wire logic [2:0] rid_code_in,
  input wire logic rid_done_in,
  output logic rid_start_out,
  // Analog switch enables
  output logic ident_pin_pullup_on_out,
  output logic bus_power_discharge_on_out,
  output logic bus_power_charge_on_out,
  output logic session_end_cmp_en_out,
  output logic bus_power_valid_cmp_en_out,
  // Receive command side
  output logic rxcmd_bus_valid_out,
  output logic rxcmd_event_out,
  output logic rxcmd_alt_int_out
);
  import oig_pkg::*;

  // ==========================================================================
  // Registers
  logic [7:0] otg_ctrl_q;
  logic [7:0] int_en_rise_q;
  logic [7:0] int_en_fall_q;
  logic [7:0] int_latch_q;
  logic [7:0] ext_ind_q;
  logic sync_mode_q;
  logic [2:0] rid_value_q;
  logic rid_busy_q;
  logic [7:0] rid_timer_q;

  // Synchronised comparator levels
  logic id_gnd_s;
  logic id_float_s;
  logic bus_valid_s;
  logic sess_valid_s;
  logic sess_end_s;

  oig_sync u_sync_idg (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .async_in(ident_grounded_cmp_in),
    .sync_out(id_gnd_s)
  );
  oig_sync u_sync_idf (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .async_in(ident_floating_cmp_in),
    .sync_out(id_float_s)
  );
  oig_sync u_sync_bv (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .async_in(bus_power_valid_cmp_in),
    .sync_out(bus_valid_s)
  );
  oig_sync u_sync_sv (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .async_in(session_valid_cmp_in),
    .sync_out(sess_valid_s)
  );
  oig_sync u_sync_se (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .async_in(session_end_cmp_in),
    .sync_out(sess_end_s)
  );

  // ==========================================================================
  // Comparator gating
  logic sess_end_on;
  logic bus_valid_on;
  assign sess_end_on = int_en_rise_q[OIG_INT_SESS_END_BIT]
    | int_en_fall_q[OIG_INT_SESS_END_BIT];
  assign bus_valid_on = int_en_rise_q[OIG_INT_BUS_VALID_BIT]
    | int_en_fall_q[OIG_INT_BUS_VALID_BIT];

  // Status bits: the comparator reports 1 for a floating pin
  logic [7:0] int_stat;
  always_comb begin
    int_stat = 8'h00;
    int_stat[OIG_INT_BUS_VALID_BIT] = bus_valid_s & bus_valid_on;
    int_stat[OIG_INT_SESS_VALID_BIT] = sess_valid_s;
    int_stat[OIG_INT_SESS_END_BIT] = sess_end_s & sess_end_on;
    int_stat[OIG_INT_ID_GND_BIT] = id_gnd_s;
  end

  // ==========================================================================
  // Edge events, each gated by its own rise and fall enables
  logic [4:0] edge_ev;
  logic float_ev;
  logic [4:0] levels;
  assign levels = int_stat[4:0];

  genvar gi;
  generate
    for (gi = 1; gi <= 4; gi++) begin : g_edge
      oig_edge u_edge (
        .clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .level_in(levels[gi]),
        .rise_en_in(int_en_rise_q[gi]),
        .fall_en_in(int_en_fall_q[gi]),
        .event_out(edge_ev[gi])
      );
    end
  endgenerate
  assign edge_ev[0] = 1'b0;

  // Float comparator events use the carkit bit of both enable registers
  oig_edge u_edge_float (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .level_in(id_float_s),
    .rise_en_in(int_en_rise_q[OIG_CK_ID_FLOAT_BIT]),
    .fall_en_in(int_en_fall_q[OIG_CK_ID_FLOAT_BIT]),
    .event_out(float_ev)
  );

  // ==========================================================================
  // APB decode
  logic wr_acc;
  logic rd_acc;
  logic addr_ok;
  assign wr_acc = psel_in & penable_in & pwrite_in;
  assign rd_acc = psel_in & penable_in & ~pwrite_in;
  always_comb begin
    case (paddr_in)
      OIG_OTG_CTRL_ADDR, OIG_INT_EN_RISE_ADDR, OIG_INT_EN_FALL_ADDR,
      OIG_INT_STAT_ADDR, OIG_INT_LATCH_ADDR, OIG_CARKIT_STAT_ADDR,
      OIG_RID_ADDR, OIG_EXT_IND_ADDR: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // ==========================================================================
  // Control registers
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      otg_ctrl_q <= OIG_CTRL_RESET;
      int_en_rise_q <= OIG_INT_EN_RESET;
      int_en_fall_q <= OIG_INT_EN_RESET;
      ext_ind_q <= OIG_EXT_RESET;
      sync_mode_q <= 1'b1;
    end else if (wr_acc && pready_out) begin
      case (paddr_in)
        OIG_OTG_CTRL_ADDR: otg_ctrl_q <= pwdata_in[7:0];
        OIG_INT_EN_RISE_ADDR: int_en_rise_q <= pwdata_in[7:0];
        OIG_INT_EN_FALL_ADDR: int_en_fall_q <= pwdata_in[7:0];
        OIG_EXT_IND_ADDR: ext_ind_q <= {5'h00, pwdata_in[2:0]};
        OIG_RID_ADDR: sync_mode_q <= pwdata_in[OIG_RID_SYNC_BIT];
        default: otg_ctrl_q <= otg_ctrl_q;
      endcase
    end
  end

  // ==========================================================================
  // Sticky event latch: a read clears only the bits it returned; new events win
  logic [7:0] new_ev;
  logic latch_rd;
  assign new_ev = {3'h0, edge_ev[4:1], float_ev};
  assign latch_rd = rd_acc && pready_out && (paddr_in == OIG_INT_LATCH_ADDR);
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      int_latch_q <= 8'h00;
    end else if (latch_rd) begin
      int_latch_q <= (int_latch_q & ~prdata_out[7:0]) | new_ev;
    end else begin
      int_latch_q <= int_latch_q | new_ev;
    end
  end

  // ==========================================================================
  // Resistance conversion; a start only counts in synchronous mode
  logic rid_start_req;
  assign rid_start_req = wr_acc && pready_out && (paddr_in == OIG_RID_ADDR)
    && pwdata_in[OIG_RID_START_BIT] && pwdata_in[OIG_RID_SYNC_BIT];
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      rid_busy_q <= 1'b0;
      rid_timer_q <= 8'h00;
      rid_value_q <= OIG_RID_FLOAT;
      rid_start_out <= 1'b0;
    end else begin
      rid_start_out <= rid_start_req && !rid_busy_q;
      if (rid_start_req && !rid_busy_q) begin
        rid_busy_q <= 1'b1;
        rid_timer_q <= 8'(OIG_RID_CONV_CYC);
      end else if (rid_busy_q) begin
        if (rid_timer_q != 8'h00) begin
          rid_timer_q <= rid_timer_q - 8'h01;
        end
        // Result is taken only after the least settling time
        if (rid_done_in && rid_timer_q == 8'h00) begin
          rid_busy_q <= 1'b0;
          rid_value_q <= rid_code_in;
        end
      end
    end
  end

  // ==========================================================================
  // Read data
  logic [7:0] rd_byte;
  always_comb begin
    case (paddr_in)
      OIG_OTG_CTRL_ADDR: rd_byte = otg_ctrl_q;
      OIG_INT_EN_RISE_ADDR: rd_byte = int_en_rise_q;
      OIG_INT_EN_FALL_ADDR: rd_byte = int_en_fall_q;
      OIG_INT_STAT_ADDR: rd_byte = int_stat;
      OIG_INT_LATCH_ADDR: rd_byte = int_latch_q;
      OIG_CARKIT_STAT_ADDR: rd_byte = {7'h00, id_float_s};
      // Code hidden outside synchronous mode
      OIG_RID_ADDR: rd_byte = {1'b0, sync_mode_q, rid_busy_q, 2'h0,
        sync_mode_q ? rid_value_q : 3'h0};
      OIG_EXT_IND_ADDR: rd_byte = ext_ind_q;
      default: rd_byte = 8'h00;
    endcase
  end

  // Zero wait state slave: answer in the cycle after setup
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      pready_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= psel_in & ~penable_in;
      pslverr_out <= psel_in & ~penable_in & ~addr_ok;
      if (psel_in && !penable_in && !pwrite_in) begin
        prdata_out <= {24'h00_0000, rd_byte};
      end
    end
  end

  // ==========================================================================
  // Outputs
  logic bus_valid_src;
  always_comb begin
    if (!ext_ind_q[OIG_EXT_USE_BIT]) begin
      bus_valid_src = int_stat[OIG_INT_BUS_VALID_BIT];
    end else if (ext_ind_q[OIG_EXT_COMPL_BIT]) begin
      bus_valid_src = 1'b0;
    end else if (ext_ind_q[OIG_EXT_PASS_BIT]) begin
      // External indicator is tied high
      bus_valid_src = 1'b1;
    end else begin
      bus_valid_src = int_stat[OIG_INT_BUS_VALID_BIT];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      ident_pin_pullup_on_out <= 1'b0;
      bus_power_discharge_on_out <= 1'b0;
      bus_power_charge_on_out <= 1'b0;
      session_end_cmp_en_out <= 1'b0;
      bus_power_valid_cmp_en_out <= 1'b0;
      rxcmd_bus_valid_out <= 1'b0;
      rxcmd_event_out <= 1'b0;
      rxcmd_alt_int_out <= 1'b0;
    end else begin
      ident_pin_pullup_on_out <= otg_ctrl_q[OIG_CTRL_ID_PULLUP_BIT];
      bus_power_discharge_on_out <= otg_ctrl_q[OIG_CTRL_DISCHARGE_BIT];
      bus_power_charge_on_out <= otg_ctrl_q[OIG_CTRL_CHARGE_BIT];
      session_end_cmp_en_out <= sess_end_on;
      bus_power_valid_cmp_en_out <= bus_valid_on;
      rxcmd_bus_valid_out <= bus_valid_src;
      rxcmd_event_out <= (|edge_ev[4:1]) | float_ev;
      rxcmd_alt_int_out <= float_ev;
    end
  end
endmodule
`default_nettype wire

// *** bench/oig_conv_model.sv ***
/*
  Behavioural model of the identification resistance converter.
  Assumes one start pulse at a time, with the code selected by the bench.
*/
`default_nettype none
module oig_conv_model #(
  parameter int DELAY = 30
) (
  input wire logic clk_in,
  input wire logic start_in,
  input wire logic [2:0] sel_in,
  output logic [2:0] code_out,
  output logic done_out
);
  // ==========================================================================
  // Conversion timer
  int cnt;
  logic [2:0] last;
  initial begin
    cnt = 0;
    last = 3'h0;
    code_out = 3'h7;
    done_out = 1'b0;
  end
  // Code is only valid with done, so it shows garbage otherwise
  always @(posedge clk_in) begin
    done_out <= 1'b0;
    code_out <= ~last;
    if (start_in) begin
      cnt <= DELAY;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (cnt == 1) begin
      cnt <= 0;
      done_out <= 1'b1;
      code_out <= sel_in;
      last <= sel_in;
    end
  end
endmodule
`default_nettype wire

// *** bench/oig_otg_ctrl_monitor.sv ***
/*
  Checker for the cable identification and bus power block.
  Sees only the top ports; bound into every instance of the block.
*/
`default_nettype none
module oig_otg_ctrl_monitor (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic ident_grounded_cmp_in,
  input wire logic ident_floating_cmp_in,
  input wire logic rid_start_out,
  input wire logic ident_pin_pullup_on_out,
  input wire logic bus_power_discharge_on_out,
  input wire logic bus_power_charge_on_out,
  input wire logic session_end_cmp_en_out,
  input wire logic bus_power_valid_cmp_en_out,
  input wire logic rxcmd_bus_valid_out,
  input wire logic rxcmd_event_out,
  input wire logic rxcmd_alt_int_out
);
  import oig_pkg::*;
  // ==========================================================================
  // Shadow of the enable registers
  logic commit;
  logic [7:0] rise_q;
  logic [7:0] fall_q;
  assign commit = psel_in && penable_in && pwrite_in && pready_out;
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      rise_q <= OIG_INT_EN_RESET;
      fall_q <= OIG_INT_EN_RESET;
    end else if (commit && paddr_in == OIG_INT_EN_RISE_ADDR) begin
      rise_q <= pwdata_in[7:0];
    end else if (commit && paddr_in == OIG_INT_EN_FALL_ADDR) begin
      fall_q <= pwdata_in[7:0];
    end
  end
  // ==========================================================================
  // Properties
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  apb_ready_a: assert property (psel_in && !penable_in |=> pready_out)
    else $error("pready missing after setup");
  ready_err_a: assert property (pslverr_out |-> pready_out)
    else $error("pslverr without pready");
  ctrl_bits_a: assert property (commit && paddr_in == OIG_OTG_CTRL_ADDR |-> ##2
    {ident_pin_pullup_on_out, bus_power_discharge_on_out, bus_power_charge_on_out} ==
    {$past(pwdata_in[0], 2), $past(pwdata_in[3], 2), $past(pwdata_in[4], 2)})
    else $error("switch enables differ from control write");
  bv_en_a: assert property (commit && paddr_in inside {8'h04, 8'h08} |-> ##2
    bus_power_valid_cmp_en_out == (rise_q[1] | fall_q[1]))
    else $error("bus valid comparator enable wrong");
  se_en_a: assert property (commit && paddr_in inside {8'h04, 8'h08} |-> ##2
    session_end_cmp_en_out == (rise_q[3] | fall_q[3]))
    else $error("session end comparator enable wrong");
  float_evt_a: assert property ($changed(ident_floating_cmp_in) && rise_q[0] && fall_q[0]
    |-> ##[2:6] (rxcmd_event_out && rxcmd_alt_int_out))
    else $error("float change gave no alternate event");
  gnd_evt_a: assert property ($fell(ident_grounded_cmp_in) && fall_q[4]
    |-> ##[2:6] rxcmd_event_out)
    else $error("grounded fall gave no event");
  alt_evt_a: assert property (rxcmd_alt_int_out |-> rxcmd_event_out)
    else $error("alternate flag without event");
  rid_refuse_a: assert property (commit && paddr_in == OIG_RID_ADDR && pwdata_in[4]
    && !pwdata_in[6] |-> ##1 !rid_start_out ##1 !rid_start_out)
    else $error("conversion started outside synchronous mode");
  bv_fixed_a: assert property (commit && paddr_in == OIG_EXT_IND_ADDR
    && pwdata_in[2:0] == 3'h3 |-> ##2 rxcmd_bus_valid_out)
    else $error("pass through did not force bus valid high");
  bv_compl_a: assert property (commit && paddr_in == OIG_EXT_IND_ADDR
    && pwdata_in[0] && pwdata_in[2] |-> ##2 !rxcmd_bus_valid_out)
    else $error("complement did not force bus valid low");
  cover property (rxcmd_alt_int_out);
  cover property (pslverr_out);
  cover property (rid_start_out);
endmodule
bind oig_otg_ctrl oig_otg_ctrl_monitor mon (.core_clk_in, .rst_n_in, .psel_in, .penable_in,
  .pwrite_in, .paddr_in, .pwdata_in, .pready_out, .pslverr_out, .ident_grounded_cmp_in,
  .ident_floating_cmp_in, .rid_start_out, .ident_pin_pullup_on_out,
  .bus_power_discharge_on_out, .bus_power_charge_on_out, .session_end_cmp_en_out,
  .bus_power_valid_cmp_en_out, .rxcmd_bus_valid_out, .rxcmd_event_out, .rxcmd_alt_int_out);
`default_nettype wire

// *** bench/oig_otg_ctrl_test.sv ***
/*
  Self-checking bench for the cable identification and bus power block.
  Assumes the converter model and the bound monitor are compiled first.
*/
`default_nettype none
module oig_otg_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  import oig_pkg::*;
  typedef struct packed {
    logic [4:0] cmp;
    logic [7:0] rise;
    logic [7:0] fall;
    logic [3:0] st;
    logic flt;
    logic [1:0] en;
  } oig_tb_row_s;
  // ==========================================================================
  // Signals
  logic core_clk_in, rst_n_in, psel_in, penable_in, pwrite_in, rid_done_in, rid_start_out;
  logic pready_out, pslverr_out, rxcmd_bus_valid_out, rxcmd_event_out, rxcmd_alt_int_out;
  logic ident_pin_pullup_on_out, bus_power_discharge_on_out, bus_power_charge_on_out;
  logic session_end_cmp_en_out, bus_power_valid_cmp_en_out, err;
  logic [7:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, r;
  logic [2:0] rid_code_in, rsel;
  logic [4:0] cmp;
  int miscompares, tests_run, k, i;
  // Comparator order: grounded, floating, bus valid, session valid, session end
  oig_tb_row_s rows [5] = '{{5'h1F, 8'h1F, 8'h1F, 4'hF, 1'h1, 2'h3},
    {5'h00, 8'h1F, 8'h1F, 4'h0, 1'h0, 2'h3}, {5'h17, 8'h00, 8'h00, 4'hA, 1'h0, 2'h0},
    {5'h0F, 8'h08, 8'h00, 4'h6, 1'h1, 2'h2}, {5'h05, 8'h00, 8'h02, 4'h1, 1'h0, 2'h1}};
  oig_otg_ctrl dut (.core_clk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .ident_grounded_cmp_in(cmp[4]),
    .ident_floating_cmp_in(cmp[3]), .bus_power_valid_cmp_in(cmp[2]),
    .session_valid_cmp_in(cmp[1]), .session_end_cmp_in(cmp[0]), .rid_code_in, .rid_done_in,
    .rid_start_out, .ident_pin_pullup_on_out, .bus_power_discharge_on_out,
    .bus_power_charge_on_out, .session_end_cmp_en_out, .bus_power_valid_cmp_en_out,
    .rxcmd_bus_valid_out, .rxcmd_event_out, .rxcmd_alt_int_out);
  oig_conv_model conv (.clk_in(core_clk_in), .start_in(rid_start_out), .sel_in(rsel),
    .code_out(rid_code_in), .done_out(rid_done_in));
  // ==========================================================================
  // Tasks
  task automatic summarize();
    $display("Compares %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  // Called just after a rising edge; returns just after one
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge core_clk_in);
    penable_in <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge core_clk_in);
      if (pready_out === 1'b1) break;
    end
    if (n == 16) begin
      miscompares++;
      summarize();
    end
    r = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge core_clk_in);
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m);
    apb(1'b0, a, 32'h0000_0000);
    chk(n, e & m, r & m);
  endtask
  task automatic ev(input string n, input logic e, input logic a);
    logic se;
    logic sa;
    se = 1'b0;
    sa = 1'b0;
    repeat (8) begin
      @(posedge core_clk_in);
      se = se | rxcmd_event_out;
      sa = sa | rxcmd_alt_int_out;
    end
    chk(n, {30'h0, e, a}, {30'h0, se, sa});
  endtask
  // ==========================================================================
  // Stimulus
  initial begin
    core_clk_in = 1'b0;
    forever #4 core_clk_in = ~core_clk_in;
  end
  initial begin
    rst_n_in = 1'b0;
    {psel_in, penable_in, pwrite_in} = 3'h0;
    paddr_in = 8'h00;
    pwdata_in = 32'h0000_0000;
    cmp = 5'h1F;
    rsel = 3'h0;
    repeat (20) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    @(posedge core_clk_in);
    rchk("ctrl_rst", OIG_OTG_CTRL_ADDR, 32'h0000_0000, 32'hFFFF_FFFF);
    rchk("rise_rst", OIG_INT_EN_RISE_ADDR, 32'h0000_001F, 32'hFFFF_FFFF);
    rchk("ext_rst", OIG_EXT_IND_ADDR, 32'h0000_0000, 32'hFFFF_FFFF);
    rchk("rid_rst", OIG_RID_ADDR, 32'h0000_0045, 32'h0000_0067);
    rchk("unmapped", 8'h20, 32'h0000_0000, 32'hFFFF_FFFF);
    chk("unmapped_err", 32'h0000_0001, {31'h0, err});
    foreach (rows[j]) begin
      apb(1'b1, OIG_INT_EN_RISE_ADDR, {24'h0, rows[j].rise});
      apb(1'b1, OIG_INT_EN_FALL_ADDR, {24'h0, rows[j].fall});
      cmp <= rows[j].cmp;
      repeat (4) @(posedge core_clk_in);
      rchk("status", OIG_INT_STAT_ADDR, {27'h0, rows[j].st, 1'b0}, 32'h1E);
      rchk("carkit", OIG_CARKIT_STAT_ADDR, {31'h0, rows[j].flt}, 32'h1);
      chk("cmp_en", {30'h0, rows[j].en},
          {30'h0, session_end_cmp_en_out, bus_power_valid_cmp_en_out});
    end
    apb(1'b1, OIG_INT_EN_RISE_ADDR, 32'h0000_001F);
    apb(1'b1, OIG_INT_EN_FALL_ADDR, 32'h0000_001F);
    // Bus valid comparator level on bit 3, selection on bits 2:0
    for (k = 0; k < 16; k++) begin
      cmp[2] <= k[3];
      apb(1'b1, OIG_EXT_IND_ADDR, {29'h0, k[2:0]});
      repeat (4) @(posedge core_clk_in);
      chk("bus_valid_src", k[0] ? (k[2] ? 0 : (k[1] ? 1 : k[3])) : k[3],
          {31'h0, rxcmd_bus_valid_out});
    end
    apb(1'b1, OIG_OTG_CTRL_ADDR, 32'h0000_0019);
    repeat (2) @(posedge core_clk_in);
    chk("switches", 32'h7, {29'h0, ident_pin_pullup_on_out, bus_power_discharge_on_out,
        bus_power_charge_on_out});
    apb(1'b1, OIG_OTG_CTRL_ADDR, 32'h0000_0008);
    repeat (2) @(posedge core_clk_in);
    chk("discharge", 32'h2, {29'h0, ident_pin_pullup_on_out, bus_power_discharge_on_out,
        bus_power_charge_on_out});
    apb(1'b1, OIG_OTG_CTRL_ADDR, 32'h0000_0000);
    cmp <= 5'h1F;
    repeat (6) @(posedge core_clk_in);
    apb(1'b0, OIG_INT_LATCH_ADDR, 32'h0000_0000);
    cmp[3] <= 1'b0;
    ev("float_evt", 1'b1, 1'b1);
    rchk("latch_float", OIG_INT_LATCH_ADDR, 32'h0000_0001, 32'h0000_00FF);
    cmp[4] <= 1'b0;
    ev("gnd_evt", 1'b1, 1'b0);
    apb(1'b1, OIG_INT_EN_RISE_ADDR, 32'h0000_001B);
    apb(1'b1, OIG_INT_EN_FALL_ADDR, 32'h0000_001B);
    cmp[1] <= 1'b0;
    ev("sv_quiet", 1'b0, 1'b0);
    rchk("sv_status", OIG_INT_STAT_ADDR, 32'h0000_000A, 32'h0000_001E);
    for (k = 0; k < 6; k++) begin
      rsel <= k[2:0];
      apb(1'b1, OIG_RID_ADDR, 32'h0000_0050);
      repeat (3) @(posedge core_clk_in);
      for (i = 0; i < 20; i++) begin
        apb(1'b0, OIG_RID_ADDR, 32'h0000_0000);
        if (r[OIG_RID_BUSY_BIT] === 1'b0) break;
      end
      if (i == 20) begin
        miscompares++;
        summarize();
      end
      chk("rid_code", k, {29'h0, r[2:0]});
    end
    apb(1'b1, OIG_RID_ADDR, 32'h0000_0010);
    rchk("rid_async", OIG_RID_ADDR, 32'h0000_0000, 32'h0000_0047);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    @(posedge core_clk_in);
    rchk("rid_rst2", OIG_RID_ADDR, 32'h0000_0045, 32'h0000_0067);
    rchk("ext_rst2", OIG_EXT_IND_ADDR, 32'h0000_0000, 32'hFFFF_FFFF);
    summarize();
  end
endmodule
`default_nettype wire
